// ---- secp_top.sv ----
// SPI command front end with status and write protection
`timescale 1ns/1ps
`include "secp_defines.svh"
module secp_top #(
   parameter int PROG_CYCLES = `SECP_PROG_CYCLES,
   parameter int PAGE_BYTES = `SECP_PAGE_BYTES
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_busy,
   output logic [7:0] o_status,
   output logic o_mem_we,
   output secp_pkg::secp_addr_t o_mem_addr,
   output logic [7:0] o_mem_wdata,
   output secp_pkg::secp_addr_t o_rd_addr,
   input wire logic [7:0] i_rd_data
);
   import secp_pkg::*;

   initial begin
      if (PROG_CYCLES < 1) $error("PROG_CYCLES must be positive");
      if (PAGE_BYTES != `SECP_PAGE_BYTES) $error("page size fixed at 64");
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: runs on serial clock; phase, shift and output flops reset by chip select high
   // Pause pin moves only with sck low, so it gates the edges directly
   wire lk_clk = i_sck;
   wire lk_go = i_hold_n & i_ce;

   // Status mirrored into link domain through two flops (quasi-static)
   logic [7:0] st_lk;
   logic [7:0] status_r;
   secp_sync #(.W(8)) u_st_sync (
      .i_clk(lk_clk),
      .i_ce(1'b1),
      .i_d(status_r),
      .o_q(st_lk)
   );

   secp_phase_e ph_r;
   logic [7:0] sh_r;
   logic [2:0] bit_r;
   logic [3:0] abit_r;
   logic [15:0] addr_r;
   logic [7:0] op_r;
   logic [7:0] tx_r;
   logic [6:0] nbytes_r;
   logic [5:0] first_col_r;
   logic wtog_r;
   logic [7:0] ws_val_r;
   logic ws_ok_r;

   wire [7:0] sh_nxt = {sh_r[6:0], i_si};
   wire frame_go = (ph_r == SECP_OP) && (bit_r == 3'h0);
   wire lk_busy = st_lk[`SECP_ST_BUSY];
   wire op_done = (ph_r == SECP_OP) && (bit_r == 3'h7);
   wire ok_op = (sh_nxt == `SECP_OP_READ_STAT) | ~lk_busy;
   wire addr_done = (ph_r == SECP_ADDR) && (abit_r == 4'hf);
   wire [15:0] addr_nxt = {addr_r[14:0], i_si};
   wire data_done = (bit_r == 3'h7);
   // Page column wraps, page bits unchanged
   wire [5:0] col_inc = addr_r[5:0] + 6'h01;

   // Shift in on rising serial clock
   always_ff @(posedge lk_clk or posedge i_cs_n) begin
      if (i_cs_n) begin
         ph_r <= SECP_OP;
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         abit_r <= 4'h0;
      end else if (lk_go) begin
         sh_r <= sh_nxt;
         bit_r <= bit_r + 3'h1;
         if (op_done) begin
            op_r <= sh_nxt;
            if (!ok_op) begin
               ph_r <= SECP_IDLE;
            end else begin
               case (sh_nxt)
                  `SECP_OP_READ_MEM: ph_r <= SECP_ADDR;
                  `SECP_OP_WRITE_MEM: ph_r <= SECP_ADDR;
                  `SECP_OP_READ_STAT: ph_r <= SECP_RSTAT;
                  `SECP_OP_WRITE_STAT: ph_r <= SECP_WSTAT;
                  default: ph_r <= SECP_IDLE;
               endcase
            end
         end else begin
            case (ph_r)
               SECP_OP: if (frame_go) op_r <= 8'h00; // Stale op gone
               SECP_ADDR: begin
                  abit_r <= abit_r + 4'h1;
                  addr_r <= addr_nxt;
                  if (addr_done) begin
                     ph_r <= (op_r == `SECP_OP_READ_MEM) ?
                        SECP_RDATA : SECP_WDATA;
                  end
               end
               SECP_WDATA: begin
                  if (data_done) begin
                     addr_r <= {addr_r[15:6], col_inc};
                  end
               end
               SECP_RDATA: begin
                  if (data_done) begin
                     addr_r <= addr_r + 16'h0001;
                  end
               end
               SECP_WSTAT: begin
                  if (data_done) begin
                     ws_val_r <= sh_nxt;
                     ph_r <= SECP_IDLE;
                  end
               end
               default: ph_r <= ph_r;
            endcase
         end
      end
   end

   // Byte events: kept past select rise so the main domain can read them
   always_ff @(posedge lk_clk) begin
      if (lk_go) begin
         if (frame_go) begin
            nbytes_r <= 7'h00;
            ws_ok_r <= 1'b0;
         end
         if (addr_done) begin
            first_col_r <= addr_nxt[5:0];
         end
         if ((ph_r == SECP_WDATA) && data_done && nbytes_r != 7'h40) begin
            nbytes_r <= nbytes_r + 7'h01;
         end
         if ((ph_r == SECP_WSTAT) && data_done) begin
            ws_ok_r <= 1'b1;
         end
      end
   end
   // Frame start marker; main reset only, sck idles then
   always_ff @(posedge lk_clk or posedge i_srst) begin
      if (i_srst) begin
         wtog_r <= 1'b0;
      end else if (lk_go && frame_go) begin
         wtog_r <= ~wtog_r;
      end
   end

   // Page buffer in link domain, one slot per column
   logic [7:0] page_mem [0:63];
   logic [63:0] col_used_r;
   wire [5:0] wr_col = addr_r[5:0];
   // Only an accepted memory write clears the used columns, so a status
   // poll cannot wipe a page still being committed
   wire page_new = op_done && ok_op && (sh_nxt == `SECP_OP_WRITE_MEM);
   always_ff @(posedge lk_clk) begin
      if (lk_go && (ph_r == SECP_WDATA) && data_done) begin
         page_mem[wr_col] <= sh_nxt;
         col_used_r[wr_col] <= 1'b1;
      end else if (lk_go && page_new) begin
         col_used_r <= 64'h0;
      end
   end

   // Output byte loaded at byte boundary, shifted on falling edge
   wire [7:0] tx_load = (ph_r == SECP_RSTAT) ? st_lk : i_rd_data;
   wire load_now = (bit_r == 3'h0);
   wire tx_phase = (ph_r == SECP_RSTAT) || (ph_r == SECP_RDATA);
   always_ff @(negedge lk_clk or posedge i_cs_n) begin
      if (i_cs_n) begin
         tx_r <= 8'h00;
      end else if (lk_go) begin
         tx_r <= load_now ? tx_load : {tx_r[6:0], 1'b0};
      end
   end
   assign o_rd_addr = addr_r[`SECP_ADDR_BITS-1:0];

   // Serial output is a pin: tri-stated when deselected or paused
   logic load_pend;
   assign o_so = tx_r[7];
   assign o_so_oe = ~i_cs_n & tx_phase & i_hold_n & ~load_pend;
   always_ff @(negedge lk_clk or posedge i_cs_n) begin
      if (i_cs_n) begin
         load_pend <= 1'b1;
      end else if (lk_go) begin
         load_pend <= ~tx_phase;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main domain: status register, protection, programming timer
   logic cs_s;
   secp_sync u_cs_sync (
      .i_clk(i_mclk),
      .i_ce(i_ce),
      .i_d(i_cs_n),
      .o_q(cs_s)
   );
   logic wp_s;
   secp_sync u_wp_sync (
      .i_clk(i_mclk),
      .i_ce(i_ce),
      .i_d(i_wp_n),
      .o_q(wp_s)
   );
   logic cs_last_r;
   wire cs_rise = cs_s & ~cs_last_r;
   logic frame_pulse;
   logic frame_seen_r;
   secp_toggle u_frame_tog (
      .i_clk(i_mclk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_tog(wtog_r),
      .o_pulse(frame_pulse)
   );

   logic latch_r;
   logic busy_r;
   logic pin_guard_r;
   logic [1:0] guard_r;
   logic [31:0] cnt_r;
   logic [6:0] prog_idx_r;
   logic prog_mem_r;
   logic [15:0] prog_base_r;

   // Link words held stable after select rises, so safe to read now
   wire [7:0] op_m = op_r;
   wire hw_guard = ~wp_s & pin_guard_r;
   wire [12:0] prog_base = addr_r[12:0];
   // Protected range by guard value
   function automatic logic guarded(input logic [1:0] g,
                                    input logic [12:0] a);
      guarded = (g == 2'h3) | ((g == 2'h2) & a[12]) |
                ((g == 2'h1) & (a[12:11] == 2'h3));
   endfunction
   wire page_locked = guarded(guard_r, {prog_base[12:6], 6'h00});
   // Acts only if this frame really clocked bits in; no stale replay
   wire cmd_end = cs_rise & frame_seen_r & ~busy_r;
   wire go_set = cmd_end & (op_m == `SECP_OP_SET_LATCH);
   wire go_clr = cmd_end & (op_m == `SECP_OP_CLR_LATCH);
   wire go_wmem = cmd_end & latch_r & ~page_locked &
                  (op_m == `SECP_OP_WRITE_MEM) & (nbytes_r != 7'h00);
   wire go_wst = cmd_end & latch_r & ~hw_guard & ws_ok_r &
                 (op_m == `SECP_OP_WRITE_STAT);
   wire prog_end = busy_r & (cnt_r == 32'd1);
   wire [7:0] status_nxt = {pin_guard_r, 3'h0, guard_r, latch_r, busy_r};

   // Select edge tracking
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cs_last_r <= 1'b1;
         frame_seen_r <= 1'b0;
      end else if (i_ce) begin
         cs_last_r <= cs_s;
         // A new frame start wins over the close of the last one
         if (frame_pulse) frame_seen_r <= 1'b1;
         else if (cs_rise) frame_seen_r <= 1'b0;
      end
   end

   // Write latch and busy flag
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         latch_r <= 1'b0;
         busy_r <= 1'b0;
         cnt_r <= 32'd0;
      end else if (i_ce) begin
         if (go_wmem | go_wst) begin
            busy_r <= 1'b1;
            cnt_r <= 32'(PROG_CYCLES);
         end else if (busy_r) begin
            cnt_r <= cnt_r - 32'd1;
            if (prog_end) begin
               busy_r <= 1'b0;
               latch_r <= 1'b0;
            end
         end
         if (go_set) latch_r <= 1'b1;
         if (go_clr) latch_r <= 1'b0;
      end
   end

   // Guard bits only via status write; reset value stands for NV store
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         guard_r <= `SECP_GUARD_RESET;
         pin_guard_r <= `SECP_PIN_GUARD_RESET;
      end else if (i_ce && go_wst) begin
         guard_r <= {ws_val_r[`SECP_ST_GUARD_HI],
                     ws_val_r[`SECP_ST_GUARD_LO]};
         pin_guard_r <= ws_val_r[`SECP_ST_PIN_GUARD];
      end
   end

   // Page commit: one buffered byte per cycle into the array port
   wire [5:0] pcol = first_col_r + prog_idx_r[5:0];
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         prog_mem_r <= 1'b0;
         prog_idx_r <= 7'h00;
         prog_base_r <= 16'h0000;
         o_mem_we <= 1'b0;
         o_mem_addr <= '0;
         o_mem_wdata <= 8'h00;
      end else if (i_ce) begin
         o_mem_we <= 1'b0;
         if (go_wmem) begin
            prog_mem_r <= 1'b1;
            prog_idx_r <= 7'h00;
            prog_base_r <= addr_r;
         end else if (prog_mem_r) begin
            prog_idx_r <= prog_idx_r + 7'h01;
            if (prog_idx_r == 7'h3f) prog_mem_r <= 1'b0;
            o_mem_we <= col_used_r[pcol];
            o_mem_addr <= {prog_base_r[12:6], pcol};
            o_mem_wdata <= page_mem[pcol];
         end
      end
   end

   // Status register and visible copies
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         status_r <= 8'h00;
         o_status <= 8'h00;
         o_busy <= 1'b0;
      end else if (i_ce) begin
         status_r <= status_nxt;
         o_status <= status_nxt;
         o_busy <= busy_r;
      end
   end
endmodule

// ---- secp_defines.svh ----
// Constants of the serial EEPROM command front end
`ifndef SECP_DEFINES_SVH
`define SECP_DEFINES_SVH
`define SECP_OP_SET_LATCH 8'h06
`define SECP_OP_CLR_LATCH 8'h04
`define SECP_OP_READ_STAT 8'h05
`define SECP_OP_WRITE_STAT 8'h01
`define SECP_OP_READ_MEM 8'h03
`define SECP_OP_WRITE_MEM 8'h02
`define SECP_ST_PIN_GUARD 7
`define SECP_ST_GUARD_HI 3
`define SECP_ST_GUARD_LO 2
`define SECP_ST_LATCH 1
`define SECP_ST_BUSY 0
`define SECP_GUARD_RESET 2'h0
`define SECP_PIN_GUARD_RESET 1'h0
`define SECP_PROG_TIME_MS 5
`define SECP_CLK_MHZ 50
`define SECP_PROG_CYCLES (`SECP_PROG_TIME_MS * 1000 * `SECP_CLK_MHZ)
`define SECP_PAGE_BYTES 64
`define SECP_ADDR_BITS 13
`endif

// ---- secp_pkg.sv ----
// Types shared by the serial EEPROM command front end
package secp_pkg;
   typedef enum logic [6:0] {
      SECP_OP = 7'b0000001,
      SECP_ADDR = 7'b0000010,
      SECP_WDATA = 7'b0000100,
      SECP_RDATA = 7'b0001000,
      SECP_RSTAT = 7'b0010000,
      SECP_WSTAT = 7'b0100000,
      SECP_IDLE = 7'b1000000
   } secp_phase_e;
   typedef logic [12:0] secp_addr_t;
endpackage

// ---- secp_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module secp_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;
   initial begin
      if (W < 1) $error("secp_sync width");
   end
   // First flop feeds only the second
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule

// ---- secp_toggle.sv ----
// Toggle-based event crossing into a destination clock
`timescale 1ns/1ps
module secp_toggle (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_tog,
   output logic o_pulse
);
   logic [1:0] s_r;
   logic last_r;
   // Edge seen only after the second stage
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_r <= 2'h0;
         last_r <= 1'b0;
         o_pulse <= 1'b0;
      end else if (i_ce) begin
         s_r <= {s_r[0], i_tog};
         last_r <= s_r[1];
         o_pulse <= s_r[1] ^ last_r;
      end
   end
endmodule

// ---- secp_host_bfm.sv ----
// Host SPI controller model driving the serial pins
`timescale 1ns/1ps
module secp_host_bfm (
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_hold_n,
   input wire logic i_so
);
   // Idle pins; sck stands still between frames
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   ////////////////////////////////////////
   // One framed transfer, MSB first; hold_at picks a bit to pause in
   task automatic frame(input logic [63:0] tx, input int nb, input bit m11,
         input int hold_at, output logic [7:0] rx);
      o_sck = m11;
      #93 o_cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         #15 o_sck = 1'b0;
         o_si = tx[nb-1-i];
         if (i == hold_at) begin
            #5 o_hold_n = 1'b0; // Pause only with sck low
            #20 o_si = ~o_si; // Must be ignored while paused
            #20 o_sck = 1'b1; // Edge during pause must be ignored
            #20 o_sck = 1'b0;
            #20 o_si = tx[nb-1-i];
            o_hold_n = 1'b1;
         end
         #15 o_sck = 1'b1;
         rx = {rx[6:0], i_so};
      end
      #15 o_sck = m11;
      #15 o_cs_n = 1'b1;
      o_si = ~o_si; // Released line shows no stale value
   endtask
endmodule

// ---- secp_top_sva.sv ----
// Port assertions of the SPI command front end
`timescale 1ns/1ps
module secp_top_sva #(
   parameter int PROG_CYCLES = 100
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_cs_n,
   input wire logic i_hold_n,
   input wire logic o_so_oe,
   input wire logic o_busy,
   input wire logic [7:0] o_status,
   input wire logic o_mem_we,
   input wire secp_pkg::secp_addr_t o_mem_addr
);
   import secp_pkg::*;
   int busy_cnt_r;
   // Busy length counter, cleared whenever idle
   always_ff @(posedge i_mclk) begin
      if (i_srst || !o_busy) busy_cnt_r <= 0;
      else busy_cnt_r <= busy_cnt_r + 1;
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   sequence s_prog_start;
      $rose(o_busy);
   endsequence
   sequence s_prog_end;
      $fell(o_busy);
   endsequence
   a_desel_hiz: assert property (i_cs_n |-> !o_so_oe)
      else $error("so driven while deselected");
   a_pause_hiz: assert property (!i_hold_n |-> !o_so_oe)
      else $error("so driven during pause");
   a_zero_bits: assert property (o_status[6:4] == 3'h0)
      else $error("status bits 6 to 4 not zero");
   a_busy_flag: assert property (s_prog_start |-> ##[0:3] o_status[0])
      else $error("busy flag missing in status");
   a_latch_first: assert property (s_prog_start |-> $past(o_status[1]))
      else $error("programming without write latch");
   a_latch_clear: assert property (s_prog_end |-> ##[0:3] !o_status[1])
      else $error("write latch kept after programming");
   a_prog_len: assert property (s_prog_end |->
      busy_cnt_r >= PROG_CYCLES - 2 && busy_cnt_r <= PROG_CYCLES + 1)
      else $error("programming length wrong");
   a_commit_busy: assert property (o_mem_we |-> o_busy)
      else $error("commit outside programming");
   a_guard_range: assert property (o_mem_we |->
      o_status[3:2] == 2'h0 ||
      (o_status[3:2] == 2'h1 && o_mem_addr < 13'h1800) ||
      (o_status[3:2] == 2'h2 && o_mem_addr < 13'h1000))
      else $error("commit into guarded range");
endmodule
bind secp_top secp_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_hold_n(i_hold_n),
   .o_so_oe(o_so_oe), .o_busy(o_busy), .o_status(o_status),
   .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr));

// ---- tb.sv ----
// Self-checking bench for the SPI command front end
`timescale 1ns/1ps
module tb;
   import secp_pkg::*;
   localparam int PROG = 100;
   logic i_mclk, i_srst, i_wp_n, sck, cs_n, si, hold_n, so, so_oe, busy;
   logic we;
   logic [7:0] status, wdata;
   secp_addr_t waddr, raddr;
   logic [7:0] mem [0:8191];
   int miscompares = 0, tests_run = 0, cycles = 0;
   // Undriven serial output floats
   wire so_line = so_oe ? so : 1'bz;
   secp_top #(.PROG_CYCLES(PROG)) u_dut (.i_mclk(i_mclk), .i_srst(i_srst),
      .i_ce(1'b1), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n),
      .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .o_busy(busy),
      .o_status(status), .o_mem_we(we), .o_mem_addr(waddr),
      .o_mem_wdata(wdata), .o_rd_addr(raddr), .i_rd_data(mem[raddr]));
   secp_host_bfm u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
      .o_hold_n(hold_n), .i_so(so_line));
   ////////////////////////////////////////
   // Clock, array model and hang guard
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      if (we) mem[waddr] <= wdata;
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Frame in mode 0,0 then the spacing that commands need
   task automatic xf(input logic [63:0] tx, input int nb,
         output logic [7:0] rx);
      u_host.frame(tx, nb, 1'b0, -1, rx);
      repeat (8) @(posedge i_mclk);
   endtask
   task automatic st(input logic [7:0] exp, input logic [7:0] mask);
      logic [7:0] rx;
      xf(16'h0500, 16, rx);
      chk(rx & mask, exp);
   endtask
   task automatic wait_idle();
      int n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(posedge i_mclk);
         n++;
      end
   endtask
   ////////////////////////////////////////
   task automatic t_latch();
      logic [7:0] rx;
      st(8'h00, 8'hff);
      xf(8'h06, 8, rx);
      xf(8'h5a, 8, rx);
      st(8'h02, 8'hff);
      u_host.frame(16'h0500, 16, 1'b1, -1, rx);
      chk(rx, 8'h02);
      u_host.frame(16'h0500, 16, 1'b0, 11, rx);
      chk(rx, 8'h02);
      xf(8'h04, 8, rx);
      st(8'h00, 8'hff);
   endtask
   task automatic t_write();
      logic [7:0] rx;
      xf(8'h06, 8, rx);
      xf({8'h02, 16'he03e, 24'ha1b2c3}, 48, rx);
      st(8'h01, 8'h01);
      xf(8'h06, 8, rx);
      wait_idle();
      st(8'h00, 8'hff);
      chk(mem[13'h003e], 8'ha1);
      chk(mem[13'h003f], 8'hb2);
      chk(mem[13'h0000], 8'hc3);
      xf({8'h03, 16'h003e, 8'h00}, 32, rx);
      chk(rx, 8'ha1);
   endtask
   task automatic t_guard();
      logic [7:0] rx;
      xf(8'h06, 8, rx);
      xf(16'h01ff, 16, rx);
      wait_idle();
      st(8'h8c, 8'hfd);
      @(posedge i_mclk);
      i_wp_n <= 1'b0;
      xf(8'h06, 8, rx);
      xf(16'h0100, 16, rx);
      st(8'h8e, 8'hff);
      xf(32'h0200405a, 32, rx);
      chk(mem[13'h0040], 8'h00);
      @(posedge i_mclk);
      i_wp_n <= 1'b1;
      xf(16'h0104, 16, rx);
      wait_idle();
      st(8'h04, 8'hfd);
      xf(8'h06, 8, rx);
      xf(32'h02180077, 32, rx);
      chk(mem[13'h1800], 8'h00);
      xf(32'h0217c066, 32, rx);
      wait_idle();
      chk(mem[13'h17c0], 8'h66);
   endtask
   ////////////////////////////////////////
   // Reset, power-up wait, then the scenarios
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
      i_srst = 1'b1;
      i_wp_n = 1'b1;
      repeat (6) @(posedge i_mclk);
      i_srst <= 1'b0;
      repeat (60) @(posedge i_mclk); // Scaled power-up delay
      t_latch();
      t_write();
      t_guard();
      results();
   end
endmodule
